// File: bench/ir_mcu_port_block_tb.sv
// Purpose: self-checking bench for the port block
// Assumes: 20 MHz clock, inputs driven 5 ns after the rising edge
// Notes: levels are checked after the synchroniser lag has run out
module ir_mcu_port_block_tb;
  import port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, stopRecovery = 0, stopMode = 0;
  logic [1:0] port0Dir = 2'h3, port0Data = 2'h0, port0PadIn;
  logic [7:0] port2DirIn = 8'hff, port2Data = 8'h00, port2PadIn;
  logic port2DirWrite = 0, port2OpenDrain = 1;
  logic [7:0] ext2 = 8'hff, port3ModeIn = 8'h00, watchdogModeIn = 8'h00;
  logic port3ModeWrite = 0, watchdogModeWrite = 0, stopRecoveryWrite = 0;
  logic [7:0] stopRecoveryIn = 8'h00, irqEdgeReg = 8'h00;
  logic [7:0] timer8ControlReg = 8'h00, timerSharedControlReg = 8'h00;
  logic [7:0] timer16ControlReg = 8'h00, portConfigReg = 8'h00;
  logic [2:0] port3DataOut = 3'h0, inPadIn = 3'h0;
  logic timer8Out = 0, timer16Out = 0;
  logic comparatorOneRaw = 0, comparatorTwoRaw = 0;
  logic [1:0] port0Out, port0OeB, port0PullEn, port0InData;
  logic [7:0] port2Out, port2OeB, port2InData;
  logic wakeOr, wakeAnd, timerEdgeIn, stopSourceBitThree, compPowerEn;
  logic [2:0] port3OutPad, port3OeB;
  logic [3:0] port3InData;
  logic extRequestZero, extRequestOne, extRequestTwo, comparatorOneResult;
  keep_regs_type keepRegs;
  int n_fail = 0, samples_checked = 0;
  int cnt0 = 0, cnt1 = 0, cnt2 = 0;  // Request pulses seen
  // Free-running clock
  initial
  begin
    forever #25 clk = ~clk;
  end
  ir_mcu_port_block dut (.*);
  // Outside world on both bidirectional ports; port 0 pads pulled up
  pad_model #(.W(8)) pads2 (.oeB(port2OeB), .dout(port2Out), .ext(ext2),
    .pad(port2PadIn));
  pad_model #(.W(2)) pads0 (.oeB(port0OeB), .dout(port0Out), .ext(2'h3),
    .pad(port0PadIn));
  // Count request pulses, one per high cycle
  always @(posedge clk)
  begin
    cnt0 <= cnt0 + int'(extRequestZero === 1'b1);
    cnt1 <= cnt1 + int'(extRequestOne === 1'b1);
    cnt2 <= cnt2 + int'(extRequestTwo === 1'b1);
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Reset state of the direction and drive controls
  task automatic t_reset();
    check("p0oe", port0OeB, 2'h3);
    check("p0pull", port0PullEn, 2'h3);
    check("p2oe", port2OeB, 8'hff);
    check("keep", keepRegs, 32'h0);
  endtask
  // Two-bit port direction, data, pull-ups and read-back
  task automatic t_port0();
    port0Dir = 2'h1;
    port0Data = 2'h1;
    tick(4);
    check("p0oe", port0OeB, 2'h1);
    check("p0out", port0Out, 2'h1);
    check("p0pull", port0PullEn, 2'h1);
    check("p0in", port0InData, 2'h1);
  endtask
  // Eight-bit port: per-bit direction, shared drive kind, wake gates
  task automatic t_port2();
    port2DirIn = 8'h0f;
    port2DirWrite = 1;
    port2Data = 8'ha5;
    port2OpenDrain = 0;
    tick(1);
    port2DirWrite = 0;
    tick(4);
    check("p2oe pp", port2OeB, 8'h0f);
    check("p2out", port2Out, 8'ha5);
    check("p2in", port2InData, 8'haf);
    port2OpenDrain = 1;
    tick(3);
    check("p2oe od", port2OeB, 8'haf);
    port2DirIn = 8'hff;
    port2DirWrite = 1;
    tick(1);
    port2DirWrite = 0;
    for (int i = 0; i < 3; i++)
    begin
      ext2 = (i == 0) ? 8'hff : (i == 1) ? 8'h01 : 8'h00;
      tick(4);
      check("wakeOr", wakeOr, ext2 != 8'h00);
      check("wakeAnd", wakeAnd, ext2 == 8'hff);
    end
  endtask
  // Edge modes, request mapping, analog diversion of bit three
  task automatic t_irq();
    int b0, b1, b2;
    for (int m = 0; m < 4; m++)
    begin
      irqEdgeReg = {2'(m), 6'h00};
      b0 = cnt0;
      b1 = cnt1;
      b2 = cnt2;
      inPadIn = 3'h7;
      tick(6);
      check("rq2 rise", cnt2 - b2, m != 0);
      check("rq0 rise", cnt0 - b0, m != 0);
      check("p3in", port3InData, 4'he);
      inPadIn = 3'h0;
      tick(6);
      check("rq2 both", cnt2 - b2, (m < 2) ? 1 : 2);
      check("rq0 both", cnt0 - b0, (m < 2) ? 1 : 2);
      check("rq1 dig", cnt1 - b1, 1);
    end
    port3ModeIn = 8'h02;
    port3ModeWrite = 1;
    tick(1);
    port3ModeWrite = 0;
    b1 = cnt1;
    inPadIn = 3'h4;
    tick(6);
    check("smr src", stopSourceBitThree, 1'b1);
    check("p3in ana", port3InData[3], 1'b0);
    check("cmp pwr", compPowerEn, 1'b1);
    // Falling edge on bit three must stay off request one
    inPadIn = 3'h0;
    tick(6);
    check("rq1 ana", cnt1 - b1, 0);
    stopMode = 1;
    tick(3);
    check("cmp stop", compPowerEn, 1'b0);
    stopMode = 0;
  endtask
  // Output routing, comparator output, edge source, open drain
  task automatic t_route();
    port3DataOut = 3'h7;
    timer8Out = 1;
    comparatorOneRaw = 1;
    portConfigReg = 8'h01;
    tick(4);
    check("cmp1", comparatorOneResult, 1'b1);
    check("out4 cmp", port3OutPad[0], 1'b1);
    comparatorOneRaw = 0;
    tick(4);
    check("out4 cmp0", port3OutPad[0], 1'b0);
    portConfigReg = 8'h00;
    timer8ControlReg = 8'h01;
    timer16ControlReg = 8'h01;
    for (int s = 0; s < 4; s++)
    begin
      timerSharedControlReg = {2'h0, 2'(s), 4'h0};
      tick(3);
      check("out4 t8", port3OutPad[0], 1'b1);
      check("out5 t16", port3OutPad[1], 1'b0);
      check("out6", port3OutPad[2], s < 2);
    end
    inPadIn = 3'h1;
    ext2 = 8'h00;
    timerSharedControlReg = 8'h00;
    tick(4);
    check("edge in1", timerEdgeIn, 1'b1);
    timerSharedControlReg = 8'h40;
    tick(4);
    check("edge p2", timerEdgeIn, 1'b0);
    check("oe pp", port3OeB, 3'h0);
    // Back to digital mode before any later recovery use
    port3ModeIn = 8'h01;
    port3ModeWrite = 1;
    timer8ControlReg = 8'h00;
    timer16ControlReg = 8'h00;
    tick(1);
    port3ModeWrite = 0;
    tick(3);
    check("oe od", port3OeB, 3'h3);
  endtask
  // Stop recovery leaves the four mode registers alone
  task automatic t_keep();
    watchdogModeIn = 8'h3c;
    stopRecoveryIn = 8'h5a;
    watchdogModeWrite = 1;
    stopRecoveryWrite = 1;
    tick(1);
    watchdogModeWrite = 0;
    stopRecoveryWrite = 0;
    stopRecovery = 1;
    tick(2);
    stopRecovery = 0;
    tick(2);
    check("keep", keepRegs, 32'h3c5aff01);
  endtask
  // Cut a hang short well past the expected run length
  initial
  begin
    #1ms;
    n_fail++;
    close_out();
  end
  initial
  begin
    tick(16);
    rst_b = 1;
    tick(1);
    t_reset();
    t_port0();
    t_port2();
    t_irq();
    t_route();
    t_keep();
    close_out();
  end
endmodule

// File: bench/pad_model.sv
// Purpose: far-side model of a group of bidirectional port pads
// Assumes: enable low means the block drives the pad
// Notes: a released pad shows the level that the outside world applies
module pad_model
#(
  parameter int W = 8
)
(
  input wire logic [W-1:0] oeB,
  input wire logic [W-1:0] dout,
  input wire logic [W-1:0] ext,
  output logic [W-1:0] pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // Each pad follows the block where it drives, else the outside level
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      pad[i] = oeB[i] ? ext[i] : dout[i];
    end
  end
endmodule

// File: core/edge_detect.sv
// Purpose: edge detector with selectable polarity
// Assumes: input already synchronised
// Notes: one-cycle pulse on selected edge
module edge_detect
  import port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic level,
  input edge_mode_type mode,
  output logic hit
);
  // Previous level
  logic prev_q;

  // Remember last level
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      prev_q <= 1'b0;
    else
      prev_q <= level;
  end

  // Decode the chosen edge
  always_comb
  begin
    case (mode)
      EDGE_FALL: hit = prev_q & ~level;
      EDGE_RISE: hit = ~prev_q & level;
      default: hit = prev_q ^ level;
    endcase
  end

  a_edge_rise: assert property (
    @(posedge clk) disable iff (!rst_b)
    (mode == EDGE_RISE && $rose(level)) |-> hit)
    else $error("rising edge missed");
endmodule

// File: core/ir_mcu_port_block.sv
// Purpose: port logic of a low-voltage microcontroller
// Assumes: one 20 MHz clock; pins are three-signal groups
// Notes: registers are plain ports written by the core
`include "port_regs.svh"

module ir_mcu_port_block
  import port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic stopRecovery,
  input wire logic stopMode,
  input wire logic [1:0] port0Dir,
  input wire logic [1:0] port0Data,
  input wire logic [1:0] port0PadIn,
  input wire logic [7:0] port2DirIn,
  input wire logic port2DirWrite,
  input wire logic port2OpenDrain,
  input wire logic [7:0] port2Data,
  input wire logic [7:0] port2PadIn,
  input wire logic [7:0] port3ModeIn,
  input wire logic port3ModeWrite,
  input wire logic [7:0] watchdogModeIn,
  input wire logic watchdogModeWrite,
  input wire logic [7:0] stopRecoveryIn,
  input wire logic stopRecoveryWrite,
  input wire logic [7:0] irqEdgeReg,
  input wire logic [7:0] timer8ControlReg,
  input wire logic [7:0] timerSharedControlReg,
  input wire logic [7:0] timer16ControlReg,
  input wire logic [7:0] portConfigReg,
  input wire logic [2:0] port3DataOut,
  input wire logic timer8Out,
  input wire logic timer16Out,
  input wire logic [2:0] inPadIn,
  input wire logic comparatorOneRaw,
  input wire logic comparatorTwoRaw,
  output logic [1:0] port0Out,
  output logic [1:0] port0OeB,
  output logic [1:0] port0PullEn,
  output logic [1:0] port0InData,
  output logic [7:0] port2Out,
  output logic [7:0] port2OeB,
  output logic [7:0] port2InData,
  output logic wakeOr,
  output logic wakeAnd,
  output logic timerEdgeIn,
  output logic [2:0] port3OutPad,
  output logic [2:0] port3OeB,
  output logic [3:0] port3InData,
  output logic extRequestZero,
  output logic extRequestOne,
  output logic extRequestTwo,
  output logic stopSourceBitThree,
  output logic compPowerEn,
  output logic comparatorOneResult,
  output keep_regs_type keepRegs
);
  // Synchronised pins
  logic [7:0] p2Sync;
  logic [1:0] p0Sync;
  logic [2:0] inSync;
  logic [1:0] cmpSync;
  // Mode register copies
  keep_regs_type keep_q;
  logic [7:0] p2Dir_q;
  // Mode decode
  logic analogMode;
  logic p3OpenDrain;
  // Source bits after analog/digital selection
  logic srcOne;
  logic srcTwo;
  // Edge hits
  logic hitOne;
  logic hitTwo;
  logic hitThree;
  edge_mode_type edgeSel;
  // Output pin values before the flop
  logic [2:0] p3OutD;

  // Pin synchronisers
  sync_two #(.WIDTH(2)) uSyncP0 (.clk(clk), .rst_b(rst_b),
    .asyncIn(port0PadIn), .syncOut(p0Sync));
  sync_two #(.WIDTH(8)) uSyncP2 (.clk(clk), .rst_b(rst_b),
    .asyncIn(port2PadIn), .syncOut(p2Sync));
  sync_two #(.WIDTH(3)) uSyncIn (.clk(clk), .rst_b(rst_b),
    .asyncIn(inPadIn), .syncOut(inSync));
  sync_two #(.WIDTH(2)) uSyncCmp (.clk(clk), .rst_b(rst_b),
    .asyncIn({comparatorTwoRaw, comparatorOneRaw}),
    .syncOut(cmpSync));

  assign analogMode = keep_q.portThreeMode[`ANALOG_BIT];
  assign p3OpenDrain = keep_q.portThreeMode[`OPEN_DRAIN_BIT];
  assign edgeSel = edge_mode_type'(
    irqEdgeReg[`IRQ_EDGE_HI_BIT:`IRQ_EDGE_LO_BIT]);

  // Analog mode takes comparator results, else digital pins
  assign srcOne = analogMode ? cmpSync[0] : inSync[0];
  assign srcTwo = analogMode ? cmpSync[1] : inSync[1];

  // Edge detection for inputs one, two, three
  edge_detect uEdgeOne (.clk(clk), .rst_b(rst_b), .level(srcOne),
    .mode(edgeSel), .hit(hitOne));
  edge_detect uEdgeTwo (.clk(clk), .rst_b(rst_b), .level(srcTwo),
    .mode(edgeSel), .hit(hitTwo));
  edge_detect uEdgeThree (.clk(clk), .rst_b(rst_b), .level(inSync[2]),
    .mode(EDGE_FALL), .hit(hitThree));

  // Mode registers: power-on reset only; stop recovery keeps them
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      keep_q <= '0;
      p2Dir_q <= `P2_RESET_DIR;
    end
    else
    begin
      // stopRecovery deliberately does not clear these
      if (watchdogModeWrite)
        keep_q.watchdogMode <= watchdogModeIn;
      if (stopRecoveryWrite)
        keep_q.stopRecovery <= stopRecoveryIn;
      if (port2DirWrite)
      begin
        keep_q.portTwoMode <= port2DirIn;
        p2Dir_q <= port2DirIn;
      end
      if (port3ModeWrite)
        keep_q.portThreeMode <= port3ModeIn;
    end
  end

  // Drive of the open-drain select for port 2, reset to open-drain
  logic p2Od_q;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      p2Od_q <= ~`P2_RESET_OD;
    else
      p2Od_q <= port2OpenDrain;
  end

  // Two-bit port drivers, push-pull; pull-up off for outputs
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      port0Out <= '0;
      port0OeB <= `P0_RESET_DIR;
      port0PullEn <= `P0_RESET_DIR;
      port0InData <= '0;
    end
    else
    begin
      port0Out <= port0Data;
      port0OeB <= port0Dir;
      port0PullEn <= port0Dir;
      // Pads read back whichever way each bit points
      port0InData <= p0Sync;
    end
  end

  // Eight-bit port: per-bit direction, global open-drain
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      port2Out <= '0;
      port2OeB <= `P2_RESET_DIR;
      port2InData <= '0;
    end
    else
    begin
      port2Out <= port2Data;
      for (int i = 0; i < 8; i++)
        // Open drain releases the line when driving a one
        port2OeB[i] <= p2Dir_q[i] | (p2Od_q & port2Data[i]);
      port2InData <= p2Sync;
    end
  end

  // STOP wake gates and timer edge source
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wakeOr <= 1'b0;
      wakeAnd <= 1'b0;
      timerEdgeIn <= 1'b0;
    end
    else
    begin
      wakeOr <= |p2Sync;
      wakeAnd <= &p2Sync;
      timerEdgeIn <= timerSharedControlReg[`EDGE_SRC_BIT] ?
        p2Sync[0] : inSync[0];
    end
  end

  // Output routing for bits four to six
  always_comb
  begin
    p3OutD = port3DataOut;
    if (portConfigReg[`COMP_OUT_BIT])
      p3OutD[0] = cmpSync[0];
    else if (timer8ControlReg[`CTR_OUT_EN_BIT])
      p3OutD[0] = timer8Out;
    if (timer16ControlReg[`CTR_OUT_EN_BIT])
      p3OutD[1] = timer16Out;
    case (timerSharedControlReg[`ROUTE_HI_BIT:`ROUTE_LO_BIT])
      2'h1: p3OutD[2] = timer8Out;
      2'h2: p3OutD[2] = timer16Out;
      2'h3: p3OutD[2] = timer8Out & timer16Out;
      default: p3OutD[2] = port3DataOut[2];
    endcase
  end

  // Six-bit port outputs and input register
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      port3OutPad <= '0;
      port3OeB <= '0;
      port3InData <= '0;
    end
    else
    begin
      port3OutPad <= p3OutD;
      port3OeB[0] <= p3OpenDrain & p3OutD[0];
      port3OeB[1] <= p3OpenDrain & p3OutD[1];
      port3OeB[2] <= 1'b0;
      port3InData[0] <= 1'b0;
      port3InData[1] <= srcOne;
      port3InData[2] <= srcTwo;
      port3InData[3] <= analogMode ? 1'b0 : inSync[2];
    end
  end

  // Interrupt requests and stop-recovery diversion
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      extRequestZero <= 1'b0;
      extRequestOne <= 1'b0;
      extRequestTwo <= 1'b0;
      stopSourceBitThree <= 1'b0;
    end
    else
    begin
      extRequestTwo <= hitOne;
      extRequestZero <= hitTwo;
      extRequestOne <= hitThree & ~analogMode;
      stopSourceBitThree <= analogMode & inSync[2];
    end
  end

  // Comparator power and result
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      compPowerEn <= 1'b0;
      comparatorOneResult <= 1'b0;
      keepRegs <= '0;
    end
    else
    begin
      compPowerEn <= analogMode & ~stopMode;
      comparatorOneResult <= cmpSync[0];
      keepRegs <= keep_q;
    end
  end

  a_comp_power: assert property (
    @(posedge clk) disable iff (!rst_b) stopMode |=> !compPowerEn)
    else $error("comparators powered in stop");
  a_req_two_map: assert property (
    @(posedge clk) disable iff (!rst_b) hitOne |=> extRequestTwo)
    else $error("request two not raised");
  a_req_zero_map: assert property (
    @(posedge clk) disable iff (!rst_b) hitTwo |=> extRequestZero)
    else $error("request zero not raised");
  a_analog_div: assert property (
    @(posedge clk) disable iff (!rst_b) analogMode |=> !extRequestOne)
    else $error("request one in analog mode");
  a_keep_regs: assert property (
    @(posedge clk) disable iff (!rst_b)
    (stopRecovery && !port3ModeWrite) |=> $stable(keep_q.portThreeMode))
    else $error("mode lost on recovery");
  a_wake_or: assert property (
    @(posedge clk) disable iff (!rst_b) (p2Sync == 8'h00) |=> !wakeOr)
    else $error("wake or wrong");
  a_wake_and: assert property (
    @(posedge clk) disable iff (!rst_b) (p2Sync == 8'hff) |=> wakeAnd)
    else $error("wake and wrong");
  a_p0_pull: assert property (
    @(posedge clk) disable iff (!rst_b) !port0Dir[0] |=> !port0PullEn[0])
    else $error("pull-up on for output");
  a_p2_pushpull: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!p2Od_q && !p2Dir_q[0]) |=> !port2OeB[0])
    else $error("push-pull bit not driven");
  a_p3_od: assert property (
    @(posedge clk) disable iff (!rst_b) !p3OpenDrain |=> port3OeB == 3'h0)
    else $error("six-bit outputs not push-pull");

  c_req_two: cover property (@(posedge clk) extRequestTwo);
  c_analog: cover property (@(posedge clk) analogMode && compPowerEn);
  c_wake: cover property (@(posedge clk) wakeAnd);
endmodule

// File: core/sync_two.sv
// Purpose: two flip-flop synchroniser for a bus of pin inputs
// Assumes: single clock clk, synchronous active-low reset
// Notes: first stage is read only by the second
module sync_two
  import port_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  // First stage, metastability catcher
  logic [WIDTH-1:0] stage1_q;

  // Two-stage capture
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      stage1_q <= '0;
      syncOut <= '0;
    end
    else
    begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end
endmodule

// File: shared/port_pkg.sv
// Purpose: types for the I/O port block
// Assumes: nothing
// Notes: edge modes and pin bundles
package port_pkg;
  // Edge selection for interrupt inputs one and two; input three is fixed to the falling edge
  typedef enum logic [1:0] {
    EDGE_FALL,
    EDGE_RISE,
    EDGE_BOTH,
    EDGE_BOTH_ALT
  } edge_mode_type;
  // Two-signal pin drive group: output, enable (low drives)
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oeB;
  } pin_drive_type;
  // Saved mode registers kept across a stop-mode recovery
  typedef struct packed {
    logic [7:0] watchdogMode;
    logic [7:0] stopRecovery;
    logic [7:0] portTwoMode;
    logic [7:0] portThreeMode;
  } keep_regs_type;
endpackage

// File: shared/port_regs.svh
// Purpose: named constants for the I/O port block
// Assumes: included by bare name; definitions only
// Notes: bit positions of the mode and control registers
`ifndef PORT_REGS_SVH
`define PORT_REGS_SVH
`define OPEN_DRAIN_BIT 0
`define ANALOG_BIT 1
`define IRQ_EDGE_LO_BIT 6
`define IRQ_EDGE_HI_BIT 7
`define ROUTE_LO_BIT 4
`define ROUTE_HI_BIT 5
`define EDGE_SRC_BIT 6
`define CTR_OUT_EN_BIT 0
`define COMP_OUT_BIT 0
`define P2_RESET_DIR 8'hff
`define P2_RESET_OD 1'h0
`define P0_RESET_DIR 2'h3
`define MODE_RESET 8'h00
`define SYNC_STAGES 2
`endif
